// *** irq_pkg.sv ***
// constants, field layouts and state types of the maskable interrupt request logic
package irq_pkg;

    // ==========================================================
    // sources
    localparam int NSRC = 3;
    localparam int NEXT = 2;
    localparam logic [1:0] SRC_TIMER_A = 2'h0;
    localparam logic [1:0] SRC_EXT0 = 2'h1;
    localparam logic [1:0] SRC_EXT1 = 2'h2;

    // ==========================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_INFO = 8'h00;
    localparam logic [7:0] IDX_TIMER_A_CTRL = 8'h56;
    localparam logic [7:0] IDX_EXT0_CTRL = 8'h5D;
    localparam logic [7:0] IDX_EXT1_CTRL = 8'h5E;
    localparam logic [7:0] IDX_SP = 8'h60;
    localparam logic [7:0] IDX_FILT_DIV = 8'h61;

    // ==========================================================
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [7:0] FILT_DIV_RST = 8'h00;
    localparam logic [NEXT-1:0] PIN_IDLE = 2'h3;

    // ==========================================================
    // digital filter: samples a level must persist for
    localparam int FILT_SAMPLES = 3;
    localparam logic [FILT_SAMPLES-1:0] FILT_SMP_RST = 3'h7;

    // ==========================================================
    // types
    typedef struct packed {
        logic [1:0] rsv;      // bits 7:6, read zero
        logic filt_en;        // bit 5, external inputs only
        logic polarity;       // bit 4, 1 rising, 0 falling
        logic req;            // bit 3, request_pending_flag
        logic [2:0] level;    // bits 2:0, 0 masks the source
    } ctrl_t;

    typedef struct packed {
        logic vld;
        logic [1:0] number;
        logic [2:0] level;
    } ack_info_t;

    typedef struct packed {
        logic [FILT_SAMPLES-1:0] smp;
        logic lvl;
    } filt_state_t;

    typedef struct packed {
        ctrl_t [NSRC-1:0] ctrl;
        logic [15:0] sp;
        logic sp_loaded;
        logic [7:0] div;
        logic [7:0] divcnt;
        logic [NEXT-1:0] sync1;
        logic [NEXT-1:0] sync2;
        logic [NEXT-1:0] lvl_prev;
        logic rdy;
        logic [31:0] prdata;
        logic slverr;
        ack_info_t info_pick;
        logic irq_req;
        ack_info_t irq_cur;
        logic ack_valid;
        ack_info_t ack_info;
    } top_state_t;

endpackage

// *** irq_pin_filter.sv ***
// digital filter of one external interrupt input
module irq_pin_filter
    import irq_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // sampling control
    input wire logic sample_en,
    input wire logic filt_en,
    // synchronised pin and filtered level
    input wire logic pin_sync,
    output logic level
);

    filt_state_t s_q;
    filt_state_t s_d;

    // ==========================================================
    // sampling and level decision
    always_comb begin
        s_d = s_q;
        if (sample_en) begin
            s_d.smp = {s_q.smp[FILT_SAMPLES-2:0], pin_sync};
        end
        // RL10 three equal samples
        if (!filt_en) begin
            s_d.lvl = pin_sync;
        end else if (s_q.smp == '1) begin
            s_d.lvl = 1'b1;
        end else if (s_q.smp == '0) begin
            s_d.lvl = 1'b0;
        end
    end

    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q.smp <= FILT_SMP_RST;
            s_q.lvl <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.lvl;

    // ==========================================================
    // checks
    a_filt_three_samples: assert property ( // RL10
        @(posedge core_clk) disable iff (rst)
        ($past(filt_en) && (s_q.lvl != $past(s_q.lvl)))
            |-> ($past(s_q.smp) == {FILT_SAMPLES{s_q.lvl}}))
        else $error("filtered level changed without three equal samples");

endmodule

// *** irq_priority_pick.sv ***
// picks the highest-priority enabled pending source
module irq_priority_pick
    import irq_pkg::*;
(
    // control registers
    input wire ctrl_t [NSRC-1:0] ctrl,
    // winner
    output ack_info_t pick
);

    // higher level wins, a tie goes to the lower source number
    always_comb begin
        pick = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (ctrl[i].req && (ctrl[i].level != 3'h0) &&
                (!pick.vld || (ctrl[i].level > pick.level))) begin
                pick.vld = 1'b1;
                pick.number = 2'(i);
                pick.level = ctrl[i].level;
            end
        end
    end

endmodule

// *** maskable_interrupt_request_logic.sv ***
// maskable interrupt request flags, acknowledge path, info read and pin filters
//
// Rules of the document for this block
// RL1 - acknowledge returns number and level, clears the acknowledged request flag
// RL2 - a read of the info address clears the top enabled request flag
// RL3 - software must not read the info address
// RL4 - stack pointer resets to zero; load it before any acknowledge
// RL5 - changing polarity or filter of a source may set its flag
// RL6 - change a control register only while its source cannot request
// RL7 - change non-flag bits with and, or, bit set or bit clear
// RL8 - clear a request flag with a plain full register write
// RL9 - delay re-enabling interrupts until the control write completes
// RL10 - filtered input level recognised only after three equal samples
// RL11 - flag set on event, held until acknowledge, info read or zero write
//
// The APB interface to the registers was left to the implementer.
module maskable_interrupt_request_logic
    import irq_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources
    input wire logic timer_a_event,
    input wire logic [NEXT-1:0] external_irq_input,
    // cpu side
    input wire logic ack_req,
    output logic irq_req,
    output ack_info_t irq_pending,
    output logic ack_valid,
    output ack_info_t ack_info,
    output logic [15:0] stack_pointer
);

    top_state_t s_q;
    top_state_t s_d;
    ack_info_t pick;
    logic [NEXT-1:0] filt_lvl;
    logic sample_en;
    logic [NSRC-1:0] set_v;
    logic [NSRC-1:0] clr_v;
    logic [NSRC-1:0] chg_v;
    logic info_commit;
    logic [1:0] pick_num;
    logic [1:0] info_num;

    // ==========================================================
    // priority pick over the current flags
    irq_priority_pick u_pick (
        .ctrl(s_q.ctrl),
        .pick(pick)
    );

    assign pick_num = pick.number;
    assign info_num = s_q.info_pick.number;

    // ==========================================================
    // filter sampling clock and per-pin filters
    assign sample_en = (s_q.divcnt >= s_q.div);

    generate
        for (genvar g = 0; g < NEXT; g++) begin : g_filt
            irq_pin_filter u_filt (
                .core_clk(core_clk),
                .rst(rst),
                .sample_en(sample_en),
                .filt_en(s_q.ctrl[int'(SRC_EXT0) + g].filt_en),
                .pin_sync(s_q.sync2[g]),
                .level(filt_lvl[g])
            );
        end
    endgenerate

    // commit edge of a read of the info address
    assign info_commit = psel && penable && s_q.rdy && !pwrite &&
                         (paddr[11:2] == {2'b00, IDX_INFO});

    // ==========================================================
    // next-state logic
    always_comb begin
        logic hit;
        logic is_ctrl;
        logic [1:0] k;
        logic [31:0] rd;
        ctrl_t w;
        hit = 1'b1;
        is_ctrl = 1'b0;
        k = SRC_TIMER_A;
        rd = 32'h0000_0000;
        w = '0;
        s_d = s_q;
        set_v = '0;
        clr_v = '0;
        chg_v = '0;
        s_d.ack_valid = 1'b0;

        // two-flop synchronisers and edge history
        s_d.sync1 = external_irq_input;
        s_d.sync2 = s_q.sync1;
        s_d.lvl_prev = filt_lvl;
        s_d.divcnt = sample_en ? 8'h00 : s_q.divcnt + 8'h01;

        // RL11 source events
        set_v[SRC_TIMER_A] = timer_a_event;
        for (int i = 0; i < NEXT; i++) begin
            if (s_q.ctrl[int'(SRC_EXT0) + i].polarity) begin
                set_v[int'(SRC_EXT0) + i] = filt_lvl[i] && !s_q.lvl_prev[i];
            end else begin
                set_v[int'(SRC_EXT0) + i] = !filt_lvl[i] && s_q.lvl_prev[i];
            end
        end

        // register decode
        case (paddr[9:2])
            IDX_INFO: begin
                rd = {26'h0, pick};
            end
            IDX_TIMER_A_CTRL: begin
                is_ctrl = 1'b1;
                k = SRC_TIMER_A;
            end
            IDX_EXT0_CTRL: begin
                is_ctrl = 1'b1;
                k = SRC_EXT0;
            end
            IDX_EXT1_CTRL: begin
                is_ctrl = 1'b1;
                k = SRC_EXT1;
            end
            IDX_SP: begin
                rd = {16'h0, s_q.sp};
            end
            IDX_FILT_DIV: begin
                rd = {24'h0, s_q.div};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        if (paddr[11:10] != 2'b00) begin
            hit = 1'b0;
        end
        if (is_ctrl) begin
            rd = {24'h0, s_q.ctrl[k]};
        end

        // apb: one wait state, effects at the edge that sees pready
        if (!(psel && penable)) begin
            s_d.rdy = 1'b0;
        end else if (!s_q.rdy) begin
            s_d.rdy = 1'b1;
            s_d.slverr = !hit;
            s_d.prdata = (hit && !pwrite) ? rd : 32'h0000_0000;
            s_d.info_pick = pick;
        end else begin
            s_d.rdy = 1'b0;
            if (pwrite && hit && is_ctrl) begin
                w = ctrl_t'(pwdata[7:0]);
                w.rsv = 2'b00;
                w.req = s_q.ctrl[k].req;
                if (k == SRC_TIMER_A) begin
                    w.polarity = 1'b0;
                    w.filt_en = 1'b0;
                end
                s_d.ctrl[k] = w;
                // RL8 written zero clears the flag
                if (!pwdata[3]) begin
                    clr_v[k] = 1'b1;
                end
                // RL5 changing the polarity or filter of a source raises its flag
                if ((w.polarity != s_q.ctrl[k].polarity) ||
                    (w.filt_en != s_q.ctrl[k].filt_en)) begin
                    chg_v[k] = 1'b1;
                end
            end else if (pwrite && hit && (paddr[9:2] == IDX_SP)) begin
                s_d.sp = pwdata[15:0];
                s_d.sp_loaded = 1'b1;
            end else if (pwrite && hit && (paddr[9:2] == IDX_FILT_DIV)) begin
                s_d.div = pwdata[7:0];
            end else if (info_commit && s_q.info_pick.vld) begin
                // RL2 info read clears the top flag, hence RL3
                clr_v[s_q.info_pick.number] = 1'b1;
            end
        end

        // RL1 acknowledge answer and flag clear
        if (ack_req) begin
            s_d.ack_valid = 1'b1;
            s_d.ack_info = pick;
            if (pick.vld) begin
                clr_v[pick.number] = 1'b1;
            end
        end

        // RL11 clear first, a same-cycle event wins
        for (int i = 0; i < NSRC; i++) begin
            if (clr_v[i]) begin
                s_d.ctrl[i].req = 1'b0;
            end
            if (set_v[i] || chg_v[i]) begin
                s_d.ctrl[i].req = 1'b1;
            end
        end

        // RL4 no request before the stack pointer is loaded
        s_d.irq_req = pick.vld && s_q.sp_loaded;
        s_d.irq_cur = pick;
    end

    // ==========================================================
    // state register
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.ctrl <= {NSRC{CTRL_RST}};
            s_q.sp <= SP_RST;
            s_q.div <= FILT_DIV_RST;
            s_q.sync1 <= PIN_IDLE;
            s_q.sync2 <= PIN_IDLE;
            s_q.lvl_prev <= PIN_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign prdata = s_q.prdata;
    assign pready = s_q.rdy;
    assign pslverr = s_q.slverr;
    assign irq_req = s_q.irq_req;
    assign irq_pending = s_q.irq_cur;
    assign ack_valid = s_q.ack_valid;
    assign ack_info = s_q.ack_info;
    assign stack_pointer = s_q.sp;

    // ==========================================================
    // checks
    a_ack_answer_info: assert property ( // RL1
        @(posedge core_clk) disable iff (rst)
        ack_req |=> (ack_valid && (ack_info == $past(pick))))
        else $error("acknowledge answer missing or wrong");

    a_ack_clears_flag: assert property ( // RL1
        @(posedge core_clk) disable iff (rst)
        (ack_req && pick.vld && !set_v[pick_num] && !chg_v[pick_num])
            |=> !s_q.ctrl[$past(pick_num)].req)
        else $error("acknowledged flag not cleared");

    a_info_read_clears: assert property ( // RL2
        @(posedge core_clk) disable iff (rst)
        (info_commit && s_q.info_pick.vld && !set_v[info_num] && !chg_v[info_num])
            |=> !s_q.ctrl[$past(info_num)].req)
        else $error("info read did not clear the top flag");

    a_sp_gates_request: assert property ( // RL4
        @(posedge core_clk) disable iff (rst)
        !s_q.sp_loaded |=> !irq_req)
        else $error("request raised before stack pointer load");

    a_sp_reset_zero: assert property ( // RL4
        @(posedge core_clk) disable iff (rst)
        !s_q.sp_loaded |-> (stack_pointer == SP_RST))
        else $error("stack pointer not zero before load");

    a_ack_no_winner: assert property ( // RL1
        @(posedge core_clk) disable iff (rst)
        (ack_req && !pick.vld) |=> !ack_info.vld)
        else $error("acknowledge without a winner reported one");

    a_apb_one_wait: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(psel && penable) |=> pready)
        else $error("apb answer not after one wait state");

    a_pready_single: assert property (
        @(posedge core_clk) disable iff (rst)
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    generate
        for (genvar i = 0; i < NSRC; i++) begin : g_chk
            a_src_change_sets: assert property ( // RL5
                @(posedge core_clk) disable iff (rst)
                chg_v[i] |=> s_q.ctrl[i].req)
                else $error("source change did not set the flag");

            a_flag_set_event: assert property ( // RL11
                @(posedge core_clk) disable iff (rst)
                set_v[i] |=> s_q.ctrl[i].req)
                else $error("event did not set the flag");

            a_flag_hold_clear: assert property ( // RL11
                @(posedge core_clk) disable iff (rst)
                (s_q.ctrl[i].req && !clr_v[i]) |=> s_q.ctrl[i].req)
                else $error("flag dropped without a clear");

            a_flag_rise_cause: assert property ( // RL11
                @(posedge core_clk) disable iff (rst)
                $rose(s_q.ctrl[i].req) |-> $past(set_v[i] || chg_v[i]))
                else $error("flag set without an event or source change");
        end
    endgenerate

endmodule

// *** cpu_core_model.sv ***
// cpu core stand-in that acknowledges pending interrupts
module cpu_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // global enable and request
    input wire logic irq_en,
    input wire logic irq_req,
    // acknowledge pulse
    output logic ack_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // acknowledge sequencer
    logic [1:0] en_dly_q;
    logic [1:0] gap_q;

    // delayed enable: the enable takes effect two cycles late
    // as after the two no-operation slots
    // acknowledge pulse: one cycle, then at least three idle cycles
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            en_dly_q <= 2'h0;
            gap_q <= 2'h0;
            ack_req <= 1'b0;
        end else begin
            en_dly_q <= {en_dly_q[0], irq_en};
            ack_req <= 1'b0;
            if (gap_q != 2'h0) begin
                gap_q <= gap_q - 2'h1;
            end else if (en_dly_q[1] && irq_req === 1'b1) begin
                ack_req <= 1'b1;
                gap_q <= 2'h3;
            end
        end
    end
endmodule

// *** maskable_interrupt_request_logic_tb_top.sv ***
// self-checking bench of the maskable interrupt request logic
module maskable_interrupt_request_logic_tb_top
    import irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // signals
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic timer_a_event = 1'b0;
    logic [NEXT-1:0] external_irq_input = PIN_IDLE;
    logic ack_req;
    logic irq_req;
    ack_info_t irq_pending;
    logic ack_valid;
    ack_info_t ack_info;
    logic [15:0] stack_pointer;
    logic irq_en = 1'b0;
    ack_info_t last_ack = 6'h00;
    int n_ack = 0;
    int n_fail = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic err;

    maskable_interrupt_request_logic maskable_interrupt_request_logic_inst (
        .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_a_event(timer_a_event),
        .external_irq_input(external_irq_input), .ack_req(ack_req),
        .irq_req(irq_req), .irq_pending(irq_pending), .ack_valid(ack_valid),
        .ack_info(ack_info), .stack_pointer(stack_pointer)
    );

    cpu_core_model cpu_core_model_inst (
        .core_clk(core_clk), .rst(rst), .irq_en(irq_en), .irq_req(irq_req),
        .ack_req(ack_req)
    );

    // clock, 10 ns period
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // capture each acknowledge answer in the cycle it stands
    always @(posedge core_clk) begin
        if (ack_valid === 1'b1) begin
            last_ack <= ack_info;
            n_ack <= n_ack + 1;
        end
    end

    // ==========================================================
    // tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer, answer taken where pready is high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        // pready is looked at on the rising edge, where the answer is taken
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready", 32'h1, 32'h0);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(name, exp, rd);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // enable interrupts until the core acknowledges once
    task automatic take_ack();
        int base;
        int n;
        base = n_ack;
        n = 0;
        irq_en <= 1'b1;
        while (n_ack == base && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        irq_en <= 1'b0;
        chk("ack seen", 32'h1, (n_ack != base) ? 32'h1 : 32'h0);
        cycles(4);
    endtask

    task automatic pin0_low(input int n);
        @(posedge core_clk);
        external_irq_input <= 2'h2;
        cycles(n);
        external_irq_input <= PIN_IDLE;
        cycles(12);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        cycles(4);
        rst <= 1'b0;
        rd_chk("sp reset", IDX_SP, {16'h0, SP_RST});
        chk("sp port", 32'h0, {16'h0, stack_pointer});
        rd_chk("timer ctrl reset", IDX_TIMER_A_CTRL, {24'h0, CTRL_RST});
        rd_chk("ext0 ctrl reset", IDX_EXT0_CTRL, {24'h0, CTRL_RST});
        rd_chk("ext1 ctrl reset", IDX_EXT1_CTRL, {24'h0, CTRL_RST});
        rd_chk("div reset", IDX_FILT_DIV, {24'h0, FILT_DIV_RST});
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        // timer bits 5:4 read zero
        apb(1'b1, IDX_TIMER_A_CTRL, 32'h33);
        rd_chk("timer ctrl bits", IDX_TIMER_A_CTRL, 32'h03);
        @(posedge core_clk);
        timer_a_event <= 1'b1;
        @(posedge core_clk);
        timer_a_event <= 1'b0;
        cycles(6);
        rd_chk("timer flag set", IDX_TIMER_A_CTRL, 32'h0B);
        chk("no irq before sp", 32'h0, {31'h0, irq_req});
        apb(1'b1, IDX_SP, 32'h1234);
        cycles(3);
        chk("sp loaded", 32'h1234, {16'h0, stack_pointer});
        chk("irq after sp", 32'h1, {31'h0, irq_req});
        chk("pending info", 32'h23, {26'h0, irq_pending});
        // acknowledge returns number, level and clears the flag
        take_ack();
        chk("ack info", 32'h23, {26'h0, last_ack});
        rd_chk("flag after ack", IDX_TIMER_A_CTRL, 32'h03);
        // info read clears the top enabled flag
        @(posedge core_clk);
        timer_a_event <= 1'b1;
        @(posedge core_clk);
        timer_a_event <= 1'b0;
        cycles(3);
        rd_chk("info read", IDX_INFO, 32'h23);
        rd_chk("flag after info", IDX_TIMER_A_CTRL, 32'h03);
        cycles(2);
        chk("irq after info", 32'h0, {31'h0, irq_req});
        // full write of zero clears the flag
        @(posedge core_clk);
        timer_a_event <= 1'b1;
        @(posedge core_clk);
        timer_a_event <= 1'b0;
        cycles(3);
        rd_chk("timer flag again", IDX_TIMER_A_CTRL, 32'h0B);
        apb(1'b1, IDX_TIMER_A_CTRL, 32'h03);
        rd_chk("flag zero write", IDX_TIMER_A_CTRL, 32'h03);
        // interrupts held off while control registers change
        // polarity change sets the flag, then cleared by software
        apb(1'b1, IDX_EXT1_CTRL, 32'h10);
        rd_chk("ext1 polarity flag", IDX_EXT1_CTRL, 32'h18);
        apb(1'b1, IDX_EXT1_CTRL, 32'h10);
        rd_chk("ext1 cleared", IDX_EXT1_CTRL, 32'h10);
        // filter selection sets the flag too
        apb(1'b1, IDX_EXT0_CTRL, 32'h22);
        rd_chk("ext0 filter flag", IDX_EXT0_CTRL, 32'h2A);
        apb(1'b1, IDX_EXT0_CTRL, 32'h22);
        rd_chk("ext0 cleared", IDX_EXT0_CTRL, 32'h22);
        // two samples low are rejected, four are taken
        pin0_low(2);
        rd_chk("short pulse", IDX_EXT0_CTRL, 32'h22);
        pin0_low(4);
        rd_chk("long pulse", IDX_EXT0_CTRL, 32'h2A);
        // level change keeps the pending flag by writing one to it
        apb(1'b1, IDX_EXT0_CTRL, 32'h2B);
        rd_chk("ext0 flag kept", IDX_EXT0_CTRL, 32'h2B);
        take_ack();
        chk("ext0 ack info", 32'h2B, {26'h0, last_ack});
        rd_chk("ext0 after ack", IDX_EXT0_CTRL, 32'h23);
        // one sample every second cycle: four cycles low are two samples
        apb(1'b1, IDX_FILT_DIV, 32'h01);
        rd_chk("div written", IDX_FILT_DIV, 32'h01);
        pin0_low(4);
        rd_chk("short at div", IDX_EXT0_CTRL, 32'h23);
        pin0_low(8);
        rd_chk("long at div", IDX_EXT0_CTRL, 32'h2B);
        conclude();
    end

    // watchdog, the sequence needs well under 2000 cycles
    initial begin
        #100us;
        n_fail++;
        conclude();
    end
endmodule
